// ==== src/sar_conv_ctrl.sv ====
// conversion control state machine and serial result readout
`include "sar_defines.svh"
`default_nettype none
module sar_conv_ctrl #(
  parameter int unsigned CONV_CYCLES = `SAR_CONV_CYCLES,
  parameter int unsigned NAP_CYCLES = `SAR_NAP_CYCLES
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial clock from the host
  input wire logic sclk,
  // control pins from the host
  input wire logic conversionTriggerN,
  input wire logic csN,
  input wire logic frameSync,
  input wire logic powerDownPin,
  // held code from the sampling array
  input wire logic [`SAR_BITS-1:0] sampleCode,
  // status and serial data out
  output logic busy,
  output logic sdo,
  output logic sdoOe,
  output logic napMode
);

  ////////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (CONV_CYCLES < 1 || CONV_CYCLES > `SAR_CNT_MAX) begin : g_bad_conv
    $error("conversion cycle count out of range");
  end
  if (NAP_CYCLES < 1 || NAP_CYCLES > `SAR_CNT_MAX) begin : g_bad_nap
    $error("nap acquisition cycle count out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic sar_pkg::sar_main_t idleState(input sar_pkg::sar_main_t cur);
    sar_pkg::sar_main_t r;
    r = '0;
    r.syncA = cur.syncA;
    r.syncB = cur.syncB;
    r.riseSeen = cur.riseSeen;
    r.fallSeen = cur.fallSeen;
    r.csPrev = 1'b1;
    r.qualifiedTriggerN = 1'b1;
    r.conv = sar_pkg::SAR_WAIT;
    r.bitIdx = `SAR_MSB_IDX;
    return r;
  endfunction

  // seeding the synchronisers with idle levels keeps a false select or edge from following reset
  function automatic sar_pkg::sar_main_t resetState();
    sar_pkg::sar_main_t r;
    r = '0;
    r.syncA = `SAR_PIN_IDLE;
    r.syncB = `SAR_PIN_IDLE;
    return idleState(r);
  endfunction

  function automatic logic [`SAR_CNT_W-1:0] countDown(input logic [`SAR_CNT_W-1:0] c);
    countDown = (c == '0) ? c : c - `SAR_CNT_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // serial clock domain

  logic riseTog;
  logic fallTog;

  sar_sclk_edges u_edges (
    .sclk(sclk),
    .rstn(rstn),
    .riseTog(riseTog),
    .fallTog(fallTog)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // core domain state

  sar_pkg::sar_main_t s;
  sar_pkg::sar_main_t next_s;

  logic trigIn;
  logic csIn;
  logic fsIn;
  logic pdIn;
  logic riseEv;
  logic fallEv;
  logic qualNow;
  logic trigFall;
  logic sampleStart;
  logic abortNow;
  logic eoc;
  logic frameStart;
  logic refresh;

  assign trigIn = s.syncB[`SAR_PIN_TRIG];
  assign csIn = s.syncB[`SAR_PIN_CS];
  assign fsIn = s.syncB[`SAR_PIN_FS];
  assign pdIn = s.syncB[`SAR_PIN_PD];
  assign riseEv = s.syncB[`SAR_PIN_RISE] ^ s.riseSeen;
  assign fallEv = s.syncB[`SAR_PIN_FALL] ^ s.fallSeen;

  // trigger changes are invisible while chip select is high
  assign qualNow = csIn ? s.qualifiedTriggerN : trigIn;
  assign trigFall = s.qualifiedTriggerN & ~qualNow;
  assign sampleStart = trigIn & ~csIn;
  assign abortNow = (s.conv == sar_pkg::SAR_CONVERT) && trigFall;
  assign eoc = (s.conv == sar_pkg::SAR_CONVERT) && !trigFall && (s.convCnt == '0);
  // chip select fall with frame sync high, or frame sync rise under chip select
  assign frameStart = (!csIn && s.csPrev && fsIn) || (!csIn && fsIn && !s.fsPrev);
  assign refresh = (eoc || abortNow) && fsIn;

  always_comb begin
    next_s = s;
    next_s.syncA = {fallTog, riseTog, powerDownPin, frameSync, csN, conversionTriggerN};
    next_s.syncB = s.syncA;
    next_s.riseSeen = s.syncB[`SAR_PIN_RISE];
    next_s.fallSeen = s.syncB[`SAR_PIN_FALL];
    next_s.csPrev = csIn;
    next_s.fsPrev = fsIn;
    next_s.qualifiedTriggerN = qualNow;
    next_s.acqCnt = countDown(s.acqCnt);

    case (s.conv)
      sar_pkg::SAR_SAMPLE: begin
        // a start command inside the post-nap acquisition is ignored
        if (trigFall && s.acqCnt == '0) begin
          next_s.conv = sar_pkg::SAR_CONVERT;
          next_s.convCnt = `SAR_CNT_W'(CONV_CYCLES - 1);
          next_s.heldSample = sampleCode;
          next_s.busy = 1'b1;
        end
      end
      sar_pkg::SAR_CONVERT: begin
        if (abortNow) begin
          next_s.conv = sar_pkg::SAR_WAIT;
          next_s.busy = 1'b0;
          next_s.outWord = `SAR_ABORT_WORD;
        end else if (eoc) begin
          next_s.busy = 1'b0;
          next_s.outWord = s.heldSample;
          if (sampleStart) begin
            next_s.conv = sar_pkg::SAR_SAMPLE;
          end else if (!qualNow) begin
            next_s.conv = sar_pkg::SAR_NAP;
            next_s.napMode = 1'b1;
          end else begin
            next_s.conv = sar_pkg::SAR_WAIT;
          end
        end else begin
          next_s.convCnt = countDown(s.convCnt);
        end
      end
      sar_pkg::SAR_WAIT: begin
        if (sampleStart) begin
          next_s.conv = sar_pkg::SAR_SAMPLE;
        end
      end
      sar_pkg::SAR_NAP: begin
        if (sampleStart) begin
          next_s.conv = sar_pkg::SAR_SAMPLE;
          next_s.napMode = 1'b0;
          next_s.acqCnt = `SAR_CNT_W'(NAP_CYCLES);
        end
      end
      default: begin
        next_s.conv = sar_pkg::SAR_WAIT;
      end
    endcase

    // readout never waits on conversion state; outWord only changes at busy fall or power down
    if (frameStart || refresh) begin
      next_s.bitIdx = `SAR_MSB_IDX;
      next_s.armed = 1'b0;
    end else begin
      if (fallEv) begin
        next_s.armed = 1'b1;
      end
      if (riseEv && s.armed && s.bitIdx != 4'h0) begin
        next_s.bitIdx = s.bitIdx - 4'h1;
      end
    end
    next_s.sdo = next_s.outWord[next_s.bitIdx];
    next_s.sdoOe = !csIn;

    // power down returns everything but the synchronisers and edge history to idle and floats the output
    if (pdIn) begin
      next_s = idleState(next_s);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= resetState();
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign sdo = s.sdo;
  assign sdoOe = s.sdoOe;
  assign napMode = s.napMode;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [`SAR_CNT_W-1:0] busyCnt;

  always_ff @(posedge clk) begin
    if (!rstn || !s.busy) begin
      busyCnt <= '0;
    end else begin
      busyCnt <= busyCnt + `SAR_CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_qual_hold: assert property (csIn && !pdIn |=> $stable(s.qualifiedTriggerN))
    else $error("qualified trigger moved while chip select high");
  chk_start_conv: assert property (
    s.conv == sar_pkg::SAR_SAMPLE && trigFall && s.acqCnt == '0 && !pdIn
    |=> s.conv == sar_pkg::SAR_CONVERT && busy)
    else $error("conversion did not start on trigger fall");
  chk_back_to_back: assert property (eoc && sampleStart && !pdIn
    |=> s.conv == sar_pkg::SAR_SAMPLE && !busy)
    else $error("no direct return to sampling");
  chk_wait_entry: assert property (eoc && !sampleStart && qualNow && !pdIn
    |=> s.conv == sar_pkg::SAR_WAIT && !napMode)
    else $error("wait state not entered at end of conversion");
  chk_nap_entry: assert property (eoc && !sampleStart && !qualNow && !pdIn
    |=> s.conv == sar_pkg::SAR_NAP && napMode)
    else $error("nap state not entered at end of conversion");
  chk_nap_acq: assert property (s.conv == sar_pkg::SAR_NAP && sampleStart && !pdIn
    |=> s.acqCnt == `SAR_CNT_W'(NAP_CYCLES) ##1 s.conv != sar_pkg::SAR_CONVERT)
    else $error("post-nap acquisition not enforced");
  chk_abort_wait: assert property (abortNow && !pdIn
    |=> s.conv == sar_pkg::SAR_WAIT && !busy && s.outWord == `SAR_ABORT_WORD)
    else $error("abort did not end in wait with abort word");
  chk_conv_length: assert property (busyCnt <= `SAR_CNT_W'(CONV_CYCLES))
    else $error("conversion ran too long");
  chk_busy_state: assert property (busy == (s.conv == sar_pkg::SAR_CONVERT))
    else $error("busy disagrees with conversion state");
  chk_pd_float: assert property (pdIn |=> !sdoOe && !busy && s.conv == sar_pkg::SAR_WAIT)
    else $error("power down did not reset and float");
  chk_code_pass: assert property (eoc && !pdIn |=> s.outWord == $past(s.heldSample))
    else $error("result word not the held code");
  chk_read_prev: assert property (
    s.conv == sar_pkg::SAR_CONVERT && !eoc && !abortNow && !pdIn
    |=> $stable(s.outWord))
    else $error("result changed during a conversion");
  chk_frame_msb: assert property (frameStart && !pdIn
    |=> s.bitIdx == `SAR_MSB_IDX && sdo == s.outWord[`SAR_BITS-1])
    else $error("frame start did not present the top bit");
  chk_refresh_msb: assert property (refresh && !pdIn
    |=> s.bitIdx == `SAR_MSB_IDX && sdo == s.outWord[`SAR_BITS-1])
    else $error("busy fall did not refresh the top bit");
  chk_shift_step: assert property (
    riseEv && s.armed && s.bitIdx != 4'h0 && !frameStart && !refresh && !pdIn
    |=> s.bitIdx == $past(s.bitIdx) - 4'h1)
    else $error("bit index did not step on a qualified rising edge");
  chk_no_early_shift: assert property (
    riseEv && !s.armed && !fallEv && !pdIn |=> $stable(s.bitIdx))
    else $error("shift before the first falling edge");

  // sequencing between commands
  chk_sample_stay: assert property (
    s.conv == sar_pkg::SAR_SAMPLE && !(trigFall && s.acqCnt == '0) && !pdIn
    |=> s.conv == sar_pkg::SAR_SAMPLE)
    else $error("sampling left without a trigger fall");
  chk_idle_hold: assert property (
    (s.conv == sar_pkg::SAR_WAIT || s.conv == sar_pkg::SAR_NAP) && !sampleStart && !pdIn
    |=> $stable(s.conv))
    else $error("wait or nap left without a sample start");
  chk_sample_start: assert property (
    (s.conv == sar_pkg::SAR_WAIT || s.conv == sar_pkg::SAR_NAP) && sampleStart && !pdIn
    |=> s.conv == sar_pkg::SAR_SAMPLE)
    else $error("sample start did not begin sampling");
  chk_nap_flag: assert property (napMode == (s.conv == sar_pkg::SAR_NAP))
    else $error("nap flag disagrees with state");
  chk_conv_count: assert property (
    s.conv == sar_pkg::SAR_CONVERT && !eoc && !abortNow && !pdIn
    |=> s.convCnt == $past(s.convCnt) - `SAR_CNT_W'(1))
    else $error("conversion counter did not step");
  chk_busy_drop: assert property ((eoc || abortNow) && !pdIn |=> !busy)
    else $error("busy still high after conversion end");
  chk_pd_clear: assert property (pdIn |=> s.outWord == '0 && !napMode)
    else $error("power down did not clear the result");
  chk_oe_select: assert property (!pdIn |=> sdoOe == !$past(csIn))
    else $error("output enable does not follow chip select");
  chk_sdo_bit: assert property (sdo == s.outWord[s.bitIdx])
    else $error("serial data is not the indexed result bit");
  chk_idle_shift: assert property (
    !riseEv && !frameStart && !refresh && !pdIn |=> $stable(s.bitIdx))
    else $error("bit index moved without a rising edge");

  cov_back_to_back: cover property (eoc && sampleStart);
  cov_fs_refresh: cover property (refresh && eoc);
  cov_nap_cycle: cover property (s.conv == sar_pkg::SAR_NAP ##[1:200] s.conv == sar_pkg::SAR_SAMPLE);
  cov_abort: cover property (abortNow);
  cov_full_frame: cover property (frameStart ##[1:1000] s.bitIdx == 4'h0);

endmodule // sar_conv_ctrl
`default_nettype wire

// ==== src/sar_defines.svh ====
// constants for the converter control and serial readout block
// Function
// - trigger is latched into the qualified trigger only while chip select is low
// - qualified trigger fall during sampling starts a conversion
// - trigger high with chip select low starts sampling from wait, nap or end
// - start condition present at conversion end goes straight to sampling
// - no start condition at conversion end enters wait or nap
// - qualified trigger low at conversion end picks nap, with longer acquisition
// - another qualified trigger fall during conversion aborts it
// - an aborted conversion ends in the wait state
// - after an abort the result word reads 0xFF00
// - readout runs independently; reads during conversion give the previous result
// - chip select fall with frame sync high drives the most significant bit at once
// - later bits shift on rising serial clock edges after a falling edge
// - chip select high then low, with frame sync high, aborts a frame and restarts at the top bit
// - frame sync rise presents the most significant bit
// - frame sync high at busy fall refreshes output with the new top bit
// - frame sync rise during a frame aborts it and starts anew
// - conversions run from the internal clock and finish within 1.1 us
// - busy is high exactly while a conversion is in progress
// - power-down input high resets the logic and floats serial data out
// - results are two's complement codes passed through unchanged
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

`define SAR_BITS 16
`define SAR_MSB_IDX 4'hF
`define SAR_ABORT_WORD 16'hFF00
`define SAR_CNT_W 8
`define SAR_CNT_MAX 255
`define SAR_CLK_PERIOD_NS 10
`define SAR_CONV_TIME_NS 1100
`define SAR_CONV_CYCLES (`SAR_CONV_TIME_NS / `SAR_CLK_PERIOD_NS)
`define SAR_NAP_RESUME_NS 300
`define SAR_NAP_CYCLES ((`SAR_NAP_RESUME_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_PIN_W 6
`define SAR_PIN_TRIG 0
`define SAR_PIN_CS 1
`define SAR_PIN_FS 2
`define SAR_PIN_PD 3
`define SAR_PIN_RISE 4
`define SAR_PIN_FALL 5
// synchroniser seed: trigger and chip select idle high, the rest low
`define SAR_PIN_IDLE 6'h03

`endif

// ==== src/sar_pkg.sv ====
// types shared by the converter control and serial readout block
`include "sar_defines.svh"
`default_nettype none
package sar_pkg;

  typedef enum logic [1:0] {SAR_SAMPLE, SAR_CONVERT, SAR_WAIT, SAR_NAP} sar_conv_t;

  typedef struct packed {
    logic [`SAR_PIN_W-1:0] syncA;
    logic [`SAR_PIN_W-1:0] syncB;
    logic riseSeen;
    logic fallSeen;
    logic armed;
    logic csPrev;
    logic fsPrev;
    logic qualifiedTriggerN;
    sar_conv_t conv;
    logic [`SAR_CNT_W-1:0] convCnt;
    logic [`SAR_CNT_W-1:0] acqCnt;
    logic [`SAR_BITS-1:0] heldSample;
    logic [`SAR_BITS-1:0] outWord;
    logic [3:0] bitIdx;
    logic busy;
    logic sdo;
    logic sdoOe;
    logic napMode;
  } sar_main_t;

  typedef struct packed {
    logic rstA;
    logic rstB;
    logic riseTog;
  } sar_edge_t;

endpackage
`default_nettype wire

// ==== src/sar_sclk_edges.sv ====
// serial clock domain: turns rising and falling serial clock edges into toggles
`include "sar_defines.svh"
`default_nettype none
module sar_sclk_edges (
  // link clock
  input wire logic sclk,
  // reset from the core domain
  input wire logic rstn,
  // edge toggles toward the core domain
  output logic riseTog,
  output logic fallTog
);

  sar_pkg::sar_edge_t s;
  sar_pkg::sar_edge_t next_s;
  logic fallState;

  // only toggles cross, so the core side never samples a multi-bit value
  always_comb begin
    next_s = s;
    next_s.rstA = rstn;
    next_s.rstB = s.rstA;
    if (!s.rstB) begin
      next_s.riseTog = 1'b0;
    end else begin
      next_s.riseTog = ~s.riseTog;
    end
  end

  always_ff @(posedge sclk) begin
    s <= next_s;
  end

  // falling edges get their own register; the reset level is borrowed from the rising side
  always_ff @(negedge sclk) begin
    if (!s.rstB) begin
      fallState <= 1'b0;
    end else begin
      fallState <= ~fallState;
    end
  end

  assign riseTog = s.riseTog;
  assign fallTog = fallState;

endmodule // sar_sclk_edges
`default_nettype wire

// ==== verification/sar_host_model.sv ====
// host model driving trigger, select, frame sync and serial clock
`default_nettype none
module sar_host_model (
  // core clock
  input wire logic clk,
  // serial data from the device
  input wire logic sdo,
  // pins toward the device
  output logic sclk,
  output logic csN,
  output logic frameSync,
  output logic conversionTriggerN
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  initial begin
    sclk = 1'h1;
    csN = 1'h1;
    frameSync = 1'h1;
    conversionTriggerN = 1'h1;
  end
  // serial clock runs around reset and inside frames, idles high
  task automatic run_sclk(input int n);
    for (int k = 0; k < n; k++) begin
      #24 sclk = 1'h0;
      #24 sclk = 1'h1;
    end
  endtask
  // pins move on core edges only, so the caller controls the quiet windows
  task automatic set_pins(input logic trigN, input logic cs, input logic fs);
    @(posedge clk);
    conversionTriggerN <= trigN;
    csN <= cs;
    frameSync <= fs;
  endtask
  // the idle step raises select or drops frame sync, so every start also restarts
  task automatic read_frame(input logic fsMode, input int nclk, output logic [15:0] word);
    word = 16'h0000;
    set_pins(conversionTriggerN, !fsMode, !fsMode);
    repeat (3) @(posedge clk);
    set_pins(conversionTriggerN, 1'h0, 1'h1);
    repeat (6) @(posedge clk);
    #1 word[15] = sdo;
    set_pins(conversionTriggerN, 1'h0, !fsMode);
    // sdo settles long after a rise, so each bit is taken at the next rise
    for (int k = 1; k <= nclk; k++) begin
      #24 sclk = 1'h0;
      #24 if (k > 1) word[16-k] = sdo;
      sclk = 1'h1;
    end
    repeat (2) @(posedge clk);
    set_pins(conversionTriggerN, !fsMode, !fsMode);
  endtask
endmodule // sar_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the converter control and serial readout block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 12;
  typedef struct packed {
    logic [15:0] code;
    logic fsMode;
  } sar_row_t;
  sar_row_t rows [5] = '{'{16'h1234, 1'h0}, '{16'h7FFF, 1'h1}, '{16'h8000, 1'h0},
    '{16'hFFFF, 1'h1}, '{16'h0000, 1'h0}};
  logic clk;
  logic rstn;
  logic powerDownPin;
  logic [15:0] sampleCode;
  logic sclk;
  logic csN;
  logic frameSync;
  logic conversionTriggerN;
  logic busy;
  logic sdo;
  logic sdoOe;
  logic napMode;
  logic [15:0] word;
  int n;
  int failCount = 0;
  int nTests = 0;
  int busyLen = 0;
  int lastLen = 0;
  ////////////////////////////////////////////////////////////////
  sar_conv_ctrl #(.CONV_CYCLES(CONV), .NAP_CYCLES(4)) sar_conv_ctrl_inst (
    .clk(clk), .rstn(rstn), .sclk(sclk), .conversionTriggerN(conversionTriggerN),
    .csN(csN), .frameSync(frameSync), .powerDownPin(powerDownPin), .sampleCode(sampleCode),
    .busy(busy), .sdo(sdo), .sdoOe(sdoOe), .napMode(napMode)
  );
  sar_host_model sar_host_model_inst (
    .clk(clk), .sdo(sdo), .sclk(sclk), .csN(csN), .frameSync(frameSync),
    .conversionTriggerN(conversionTriggerN)
  );
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // busy high time in core cycles, latched at each fall
  always @(posedge clk) begin
    if (busy === 1'h1) begin
      busyLen <= busyLen + 1;
    end else if (busyLen != 0) begin
      lastLen <= busyLen;
      busyLen <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic pins(input logic t, input logic c, input logic f);
    sar_host_model_inst.set_pins(t, c, f);
  endtask
  // a wait that must succeed ends the run when its bound runs out
  task automatic wait_busy(input logic lvl, input int lim, input logic must);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (must && busy !== lvl) begin
      failCount++;
      conclude();
    end
  endtask
  task automatic convert(input logic [15:0] code, input logic fs, input logic trigAfter);
    @(posedge clk);
    sampleCode <= code;
    pins(1'h1, 1'h0, fs);
    repeat (8) @(posedge clk);
    pins(1'h0, 1'h0, fs);
    #1 wait_busy(1'h1, 10, 1'h1);
    pins(trigAfter, 1'h0, fs);
    #1 wait_busy(1'h0, 200, 1'h1);
    // keep read starts clear of the busy fall
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'h0;
    powerDownPin = 1'h0;
    sampleCode = 16'h0000;
    // sclk runs past the release so the serial side leaves reset before the first frame
    fork
      sar_host_model_inst.run_sclk(6);
      begin
        repeat (12) @(posedge clk);
        #1 check("reset outputs", {13'h0, busy, sdoOe, napMode}, 16'h0000);
        @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        #1 check("after release", {13'h0, busy, sdoOe, napMode}, 16'h0000);
      end
    join
    repeat (3) @(posedge clk);
    sar_host_model_inst.read_frame(1'h0, 16, word);
    check("reset word", word, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      convert(rows[i].code, !rows[i].fsMode, 1'h1);
      check("busy length", 16'(lastLen), 16'(CONV));
      check("back to back", {15'h0, napMode}, 16'h0000);
      sar_host_model_inst.read_frame(rows[i].fsMode, 16, word);
      check("read word", word, rows[i].code);
    end
    pins(1'h0, 1'h1, 1'h1);
    #1 wait_busy(1'h1, 10, 1'h0);
    check("gated trigger", 16'(n), 16'h000A);
    pins(1'h1, 1'h1, 1'h1);
    pins(1'h1, 1'h0, 1'h1);
    repeat (8) @(posedge clk);
    pins(1'h0, 1'h0, 1'h1);
    #1 wait_busy(1'h1, 10, 1'h1);
    pins(1'h1, 1'h0, 1'h1);
    repeat (2) @(posedge clk);
    pins(1'h0, 1'h0, 1'h1);
    #1 wait_busy(1'h0, 20, 1'h1);
    repeat (10) @(posedge clk);
    #1 check("abort length", 16'(lastLen < CONV), 16'h0001);
    check("wait state", {14'h0, busy, napMode}, 16'h0000);
    sar_host_model_inst.read_frame(1'h0, 16, word);
    check("abort word", word, 16'hFF00);
    convert(16'h0F0F, 1'h1, 1'h0);
    check("nap entry", {15'h0, napMode}, 16'h0001);
    pins(1'h1, 1'h0, 1'h1);
    pins(1'h0, 1'h0, 1'h1);
    #1 wait_busy(1'h1, 10, 1'h0);
    check("early trigger", {napMode, 15'(n)}, 16'h000A);
    convert(16'h3C3C, 1'h1, 1'h1);
    sar_host_model_inst.read_frame(1'h0, 16, word);
    check("after nap", word, 16'h3C3C);
    pins(1'h1, 1'h0, 1'h0);
    pins(1'h1, 1'h0, 1'h1);
    repeat (6) @(posedge clk);
    #1 check("frame top bit", {14'h0, sdoOe, sdo}, 16'h0002);
    @(posedge clk);
    sampleCode <= 16'h8000;
    pins(1'h0, 1'h0, 1'h1);
    #1 wait_busy(1'h1, 10, 1'h1);
    pins(1'h1, 1'h0, 1'h1);
    #1 check("old top bit", {15'h0, sdo}, 16'h0000);
    wait_busy(1'h0, 200, 1'h1);
    repeat (4) @(posedge clk);
    #1 check("refreshed top bit", {15'h0, sdo}, 16'h0001);
    for (int m = 0; m < 2; m++) begin
      sar_host_model_inst.read_frame(m[0], 5, word);
      sar_host_model_inst.read_frame(m[0], 16, word);
      check("restarted word", word, 16'h8000);
    end
    @(posedge clk);
    powerDownPin <= 1'h1;
    repeat (4) @(posedge clk);
    #1 check("power down", {13'h0, busy, sdoOe, napMode}, 16'h0000);
    @(posedge clk);
    powerDownPin <= 1'h0;
    repeat (4) @(posedge clk);
    #1 check("resume", {15'h0, sdoOe}, 16'h0001);
    conclude();
  end
endmodule // tb
`default_nettype wire
